//--- rsw_pkg.sv
// Shared types and constants for the receive status word and receiver control block
package rsw_pkg;

  // APB register byte offsets
  localparam logic [7:0] RSW_ADDR_CTRL = 8'h00;
  localparam logic [7:0] RSW_ADDR_STAT = 8'h04;
  localparam logic [7:0] RSW_ADDR_INFO = 8'h08;
  localparam logic [7:0] RSW_ADDR_SPORT = 8'h0C;
  localparam logic [7:0] RSW_ADDR_DPORT = 8'h10;
  localparam logic [7:0] RSW_ADDR_SRST = 8'h14;

  // Control register fields
  localparam int RSW_CTRL_EN_BIT = 0;
  localparam int RSW_CTRL_PASSBAD_BIT = 1;
  localparam int RSW_CTRL_CSUM_BIT = 2;
  localparam logic [2:0] RSW_CTRL_RST = 3'h0;

  // Status and soft reset register fields
  localparam int RSW_STAT_ON_BIT = 0;
  localparam int RSW_STAT_ERR_BIT = 1;
  localparam int RSW_SRST_BIT = 0;

  // Fifo info register fields
  localparam int RSW_INFO_DCNT_LO = 0;
  localparam int RSW_INFO_SCNT_LO = 16;

  // Frame size thresholds in bytes, header byte indices and dribble bit counts
  localparam logic [13:0] RSW_RUNT_BYTES = 14'h0040;
  localparam logic [13:0] RSW_MAX_FRAME_BYTES = 14'h05EE;
  localparam logic [13:0] RSW_WDOG_BYTES = 14'h0800;
  localparam logic [13:0] RSW_HDR_BYTES = 14'h000E;
  localparam logic [13:0] RSW_OVERHEAD_BYTES = 14'h0012;
  localparam logic [15:0] RSW_MAX_LEN_FIELD = 16'h05DC;
  localparam logic [13:0] RSW_DA_BYTES = 14'h0006;
  localparam logic [13:0] RSW_LTF_HI_IDX = 14'h000C;
  localparam logic [13:0] RSW_LTF_LO_IDX = 14'h000D;
  localparam logic [2:0] RSW_DRIB_MII = 3'h4;
  localparam logic [2:0] RSW_DRIB_10M = 3'h3;

  // Receive sequencer states
  typedef enum logic [1:0] {
    RSW_RX_IDLE = 2'b00,
    RSW_RX_FRAME = 2'b01,
    RSW_RX_CSUM = 2'b10,
    RSW_RX_STAT = 2'b11
  } rsw_rx_state_t;

  // One byte from the mac interface layer
  typedef struct packed {
    logic vld;
    logic sof;
    logic eof;
    logic rx_er;
    logic [7:0] data;
  } rsw_mil_t;

  // Frame attributes, valid with the last byte
  typedef struct packed {
    logic filt_fail;
    logic crc_err;
    logic late_col;
    logic speed10;
    logic [2:0] dribble_bits;
    logic [31:0] csum;
  } rsw_end_t;

  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rsw_apb_req_t;

  // Receive status word, bit 31 down to bit 0
  typedef struct packed {
    logic rsvd31;
    logic filt_fail;
    logic [13:0] len;
    logic error_summary;
    logic rsvd14;
    logic bcast;
    logic size_field_mismatch;
    logic runt;
    logic mcast;
    logic [1:0] rsvd9_8;
    logic too_long;
    logic late_col;
    logic frame_type;
    logic wdog;
    logic mii_err;
    logic dribble;
    logic crc_err;
    logic rsvd0;
  } rsw_status_t;

endpackage

//--- rsw_rx_ctrl.sv
// Receive status word builder, receive fifos and receiver stop control with APB access
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Checksum enabled: append four checksum bytes
// - Reserved status bits 31,14,9:8,0 read zero
// - Bit 30 set on address filter fail
// - Bits 29:16 hold frame size in bytes
// - Bit 15 is OR of 11,7,6,1
// - Bit 13 set for broadcast destination
// - Bit 12 set on length field mismatch
// - Bit 11 runt; delivered only if pass-bad
// - Bit 10 set for multicast destination
// - Bit 7 above 1518 bytes, no truncation
// - Bit 6 set on late collision
// - Bit 5 type frame; never under 14 bytes
// - Bit 4 set when watchdog length exceeded
// - Bit 3 set if RX_ER seen in frame
// - Bit 2 dribble bits; never with bit 6
// - Bit 1 on CRC error or RX_ER
// - One stopped pulse once receiver halts
// - Error flag on underruns or status overrun
// - Receiver keeps running after error flag
// - Soft reset restores host synchronisation
// - Status pushed after all frame data
module rsw_rx_ctrl
  import rsw_pkg::*;
#(
  parameter int DDEPTH = 64,
  parameter int SDEPTH = 8
)(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire rsw_mil_t i_mil,
  input wire rsw_end_t i_end,
  input wire rsw_apb_req_t i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_rx_on,
  output logic o_receiver_stopped_pulse,
  output logic o_receive_error_flag
);

  localparam int DAW = $clog2(DDEPTH);
  localparam int SAW = $clog2(SDEPTH);

  // Whole module state
  typedef struct packed {
    rsw_rx_state_t rx;
    logic [2:0] ctrl;
    logic rx_on;
    logic stop_pulse;
    logic err_flag;
    logic [13:0] len;
    logic da_all_ones;
    logic da_group;
    logic [15:0] ltf;
    logic rx_er_seen;
    logic drop;
    logic [31:0] acc;
    logic [1:0] bcnt;
    rsw_end_t fend;
    logic [DAW:0] dwp;
    logic [DAW:0] dcp;
    logic [DAW:0] drp;
    logic [SAW:0] swp;
    logic [SAW:0] srp;
    logic [DDEPTH-1:0][31:0] dmem;
    logic [SDEPTH-1:0][31:0] smem;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } rsw_state_t;

  rsw_state_t s_reg; // Registered state
  rsw_state_t s_next; // Next state
  rsw_status_t stat_c; // Status word of the frame being closed
  logic push_c; // Status word pushed this cycle
  logic access_c; // APB access phase
  logic done_c; // APB transfer completes at this edge
  logic d_full_c; // Data fifo full
  logic s_full_c; // Status fifo full
  logic s_empty_c; // Status fifo empty
  logic d_empty_c; // No committed data word
  logic [DAW:0] dcnt_c; // Committed words readable
  logic [SAW:0] scnt_c; // Status words readable
  logic [13:0] pay_c; // Length minus header and crc
  logic discard_c; // Frame is dropped at close
  logic ovr_c; // Status fifo overrun at this close

  // Fifo levels; the reader only sees data committed with a status word
  always_comb
  begin
    dcnt_c = s_reg.dcp - s_reg.drp;
    scnt_c = s_reg.swp - s_reg.srp;
    d_empty_c = (dcnt_c == '0);
    s_empty_c = (scnt_c == '0);
    d_full_c = ((s_reg.dwp - s_reg.drp) == (DAW + 1)'(DDEPTH));
    s_full_c = (scnt_c == (SAW + 1)'(SDEPTH));
    access_c = i_apb.psel & i_apb.penable;
    done_c = access_c & s_reg.pready;
  end

  // Status word assembly from what was gathered over the frame
  always_comb
  begin
    pay_c = s_reg.len - RSW_OVERHEAD_BYTES;
    stat_c = '0; // Reserved bits stay zero
    stat_c.filt_fail = s_reg.fend.filt_fail;
    stat_c.len = s_reg.len;
    stat_c.bcast = s_reg.da_all_ones & (s_reg.len >= RSW_DA_BYTES);
    stat_c.mcast = s_reg.da_group & ~stat_c.bcast;
    stat_c.runt = (s_reg.len < RSW_RUNT_BYTES);
    stat_c.too_long = (s_reg.len > RSW_MAX_FRAME_BYTES);
    stat_c.late_col = s_reg.fend.late_col;
    // Short frames have no length field worth judging
    stat_c.frame_type = (s_reg.len >= RSW_HDR_BYTES) & (s_reg.ltf > RSW_MAX_LEN_FIELD);
    stat_c.size_field_mismatch = (s_reg.len >= RSW_HDR_BYTES)
      & (s_reg.ltf <= RSW_MAX_LEN_FIELD) & (s_reg.ltf != {2'b00, pay_c});
    stat_c.wdog = (s_reg.len > RSW_WDOG_BYTES);
    stat_c.mii_err = s_reg.rx_er_seen;
    // Dribble threshold depends on the line rate; a late collision masks it
    stat_c.dribble = ~s_reg.fend.late_col & (s_reg.fend.speed10
      ? (s_reg.fend.dribble_bits >= RSW_DRIB_10M)
      : (s_reg.fend.dribble_bits == RSW_DRIB_MII));
    stat_c.crc_err = s_reg.fend.crc_err | s_reg.rx_er_seen;
    stat_c.error_summary = stat_c.runt | stat_c.too_long
      | stat_c.late_col | stat_c.crc_err;
    discard_c = s_reg.drop | (stat_c.runt & ~s_reg.ctrl[RSW_CTRL_PASSBAD_BIT]);
    push_c = (s_reg.rx == RSW_RX_STAT) & i_ce & ~discard_c & ~s_full_c;
    ovr_c = (s_reg.rx == RSW_RX_STAT) & ~discard_c & s_full_c;
  end

  // Next-state logic for the sequencer, fifos and register port
  always_comb
  begin
    s_next = s_reg;
    s_next.stop_pulse = 1'b0;
    // Receiver on/off; a stop only completes between frames
    if (s_reg.ctrl[RSW_CTRL_EN_BIT] & ~s_reg.rx_on)
    begin
      s_next.rx_on = 1'b1;
    end
    else if (~s_reg.ctrl[RSW_CTRL_EN_BIT] & s_reg.rx_on & (s_reg.rx == RSW_RX_IDLE))
    begin
      s_next.rx_on = 1'b0;
      s_next.stop_pulse = 1'b1;
    end
    // Frame sequencer
    case (s_reg.rx)
      RSW_RX_IDLE:
      begin
        // Mid-frame bytes are ignored so a late enable never splits a frame
        if (i_mil.vld & i_mil.sof & s_reg.rx_on & s_reg.ctrl[RSW_CTRL_EN_BIT])
        begin
          s_next.rx = RSW_RX_FRAME;
          s_next.len = '0;
          s_next.da_all_ones = 1'b1;
          s_next.da_group = 1'b0;
          s_next.ltf = '0;
          s_next.rx_er_seen = 1'b0;
          s_next.drop = 1'b0;
          s_next.acc = '0;
          s_next.bcnt = '0;
        end
      end
      RSW_RX_CSUM:
      begin
        // Checksum occupies one extra data word after the payload
        if (d_full_c)
        begin
          s_next.drop = 1'b1;
        end
        else if (~s_reg.drop)
        begin
          s_next.dmem[s_reg.dwp[DAW-1:0]] = s_reg.fend.csum;
          s_next.dwp = s_reg.dwp + 1'b1;
        end
        s_next.rx = RSW_RX_STAT;
      end
      RSW_RX_STAT:
      begin
        if (push_c)
        begin
          s_next.smem[s_reg.swp[SAW-1:0]] = stat_c;
          s_next.swp = s_reg.swp + 1'b1;
          s_next.dcp = s_reg.dwp; // Data becomes visible with its status
        end
        else
        begin
          s_next.dwp = s_reg.dcp; // Roll back a dropped frame's data
        end
        if (ovr_c)
        begin
          s_next.err_flag = 1'b1; // Status overrun
        end
        s_next.rx = RSW_RX_IDLE;
      end
      default:
      begin
        s_next.rx = s_reg.rx;
      end
    endcase
    // Byte intake, shared by the first byte and the rest of the frame
    if (((s_reg.rx == RSW_RX_IDLE) & (s_next.rx == RSW_RX_FRAME))
      | ((s_reg.rx == RSW_RX_FRAME) & i_mil.vld))
    begin
      // Length saturates; reception is never cut short
      if (s_next.len != 14'h3FFF)
      begin
        s_next.len = s_next.len + 1'b1;
      end
      if (s_next.len <= RSW_DA_BYTES)
      begin
        s_next.da_all_ones = s_next.da_all_ones & (i_mil.data == 8'hFF);
      end
      if (s_next.len == 14'h0001)
      begin
        s_next.da_group = i_mil.data[0];
      end
      if (s_next.len == RSW_LTF_HI_IDX + 1'b1)
      begin
        s_next.ltf[15:8] = i_mil.data;
      end
      if (s_next.len == RSW_LTF_LO_IDX + 1'b1)
      begin
        s_next.ltf[7:0] = i_mil.data;
      end
      s_next.rx_er_seen = s_next.rx_er_seen | i_mil.rx_er;
      s_next.acc[{s_next.bcnt, 3'b000} +: 8] = i_mil.data;
      s_next.bcnt = s_next.bcnt + 1'b1;
      // Store each full word, and the partial last word zero padded
      if ((s_next.bcnt == 2'b00) | i_mil.eof)
      begin
        if (d_full_c)
        begin
          s_next.drop = 1'b1; // No room: the frame is lost whole
        end
        else if (~s_next.drop)
        begin
          s_next.dmem[s_reg.dwp[DAW-1:0]] = s_next.acc;
          s_next.dwp = s_reg.dwp + 1'b1;
        end
        s_next.acc = '0;
        s_next.bcnt = '0;
      end
      if (i_mil.eof)
      begin
        s_next.fend = i_end;
        s_next.rx = s_reg.ctrl[RSW_CTRL_CSUM_BIT] ? RSW_RX_CSUM : RSW_RX_STAT;
      end
      else
      begin
        s_next.rx = RSW_RX_FRAME;
      end
    end
    // APB: the first access cycle prepares data, the second completes
    s_next.pready = access_c & ~s_reg.pready;
    if (access_c & ~s_reg.pready)
    begin
      s_next.pslverr = 1'b0;
      s_next.prdata = '0;
      case (i_apb.paddr)
        RSW_ADDR_CTRL: s_next.prdata[2:0] = s_reg.ctrl;
        RSW_ADDR_STAT:
        begin
          s_next.prdata[RSW_STAT_ON_BIT] = s_reg.rx_on;
          s_next.prdata[RSW_STAT_ERR_BIT] = s_reg.err_flag;
        end
        RSW_ADDR_INFO:
        begin
          s_next.prdata[RSW_INFO_DCNT_LO +: DAW + 1] = dcnt_c;
          s_next.prdata[RSW_INFO_SCNT_LO +: SAW + 1] = scnt_c;
        end
        RSW_ADDR_SPORT: s_next.prdata = s_empty_c ? '0 : s_reg.smem[s_reg.srp[SAW-1:0]];
        RSW_ADDR_DPORT: s_next.prdata = d_empty_c ? '0 : s_reg.dmem[s_reg.drp[DAW-1:0]];
        RSW_ADDR_SRST: s_next.prdata = '0;
        default: s_next.pslverr = 1'b1; // Unmapped address
      endcase
    end
    // Side effects happen only at the completing edge
    if (done_c)
    begin
      if (i_apb.pwrite & (i_apb.paddr == RSW_ADDR_CTRL))
      begin
        s_next.ctrl = i_apb.pwdata[2:0];
      end
      // A clear never swallows an overrun that happens in the same cycle
      if (i_apb.pwrite & (i_apb.paddr == RSW_ADDR_STAT) & i_apb.pwdata[RSW_STAT_ERR_BIT]
        & ~ovr_c)
      begin
        s_next.err_flag = 1'b0; // Write one to clear; the host decides when
      end
      if (~i_apb.pwrite & (i_apb.paddr == RSW_ADDR_SPORT))
      begin
        if (s_empty_c)
        begin
          s_next.err_flag = 1'b1; // Status underrun
        end
        else
        begin
          s_next.srp = s_reg.srp + 1'b1;
        end
      end
      if (~i_apb.pwrite & (i_apb.paddr == RSW_ADDR_DPORT))
      begin
        if (d_empty_c)
        begin
          s_next.err_flag = 1'b1; // Data underrun
        end
        else
        begin
          s_next.drp = s_reg.drp + 1'b1;
        end
      end
      // Soft reset: empties both fifos and clears the flag, keeps control
      if (i_apb.pwrite & (i_apb.paddr == RSW_ADDR_SRST) & i_apb.pwdata[RSW_SRST_BIT])
      begin
        s_next.rx = RSW_RX_IDLE;
        s_next.err_flag = 1'b0;
        s_next.dwp = '0;
        s_next.dcp = '0;
        s_next.drp = '0;
        s_next.swp = '0;
        s_next.srp = '0;
      end
    end
    // The error flag never touches rx_on, so reception carries on
  end

  // State register; reset clears the whole state, memories included
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_reg <= '0;
      s_reg.rx <= RSW_RX_IDLE;
      s_reg.ctrl <= RSW_CTRL_RST;
    end
    else if (i_ce)
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_prdata = s_reg.prdata;
  assign o_pready = s_reg.pready;
  assign o_pslverr = s_reg.pslverr;
  assign o_rx_on = s_reg.rx_on;
  assign o_receiver_stopped_pulse = s_reg.stop_pulse;
  assign o_receive_error_flag = s_reg.err_flag;

  // Checks
  property p_rsvd_zero;
    @(posedge i_clk) disable iff (i_srst)
    push_c |-> (stat_c.rsvd31 == 1'b0) && (stat_c.rsvd14 == 1'b0)
      && (stat_c.rsvd9_8 == 2'b00) && (stat_c.rsvd0 == 1'b0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved status bit set");

  property p_err_sum;
    @(posedge i_clk) disable iff (i_srst)
    push_c |=> s_reg.smem[$past(s_reg.swp[SAW-1:0])][15]
      == |{s_reg.smem[$past(s_reg.swp[SAW-1:0])][11], s_reg.smem[$past(s_reg.swp[SAW-1:0])][7],
           s_reg.smem[$past(s_reg.swp[SAW-1:0])][6], s_reg.smem[$past(s_reg.swp[SAW-1:0])][1]};
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("error summary mismatch");

  property p_runt_pass;
    @(posedge i_clk) disable iff (i_srst)
    push_c && stat_c.runt |-> s_reg.ctrl[RSW_CTRL_PASSBAD_BIT];
  endproperty
  a_runt_pass: assert property (p_runt_pass) else $error("runt delivered");

  property p_stop_once;
    @(posedge i_clk) disable iff (i_srst)
    $fell(s_reg.rx_on) |-> s_reg.stop_pulse ##1 (!s_reg.stop_pulse || !i_ce);
  endproperty
  a_stop_once: assert property (p_stop_once) else $error("stop pulse wrong");

  property p_keep_running;
    @(posedge i_clk) disable iff (i_srst)
    $rose(s_reg.err_flag) && s_reg.ctrl[RSW_CTRL_EN_BIT] |-> s_reg.rx_on;
  endproperty
  a_keep_running: assert property (p_keep_running) else $error("receiver halted");

  property p_underrun;
    @(posedge i_clk) disable iff (i_srst)
    i_ce && done_c && !i_apb.pwrite && (i_apb.paddr == RSW_ADDR_SPORT) && s_empty_c
      |=> s_reg.err_flag;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged");

  property p_commit;
    @(posedge i_clk) disable iff (i_srst)
    push_c |=> (s_reg.dcp == s_reg.dwp) && (s_reg.swp == $past(s_reg.swp) + 1'b1);
  endproperty
  a_commit: assert property (p_commit) else $error("status before data");

  property p_no_drib_col;
    @(posedge i_clk) disable iff (i_srst)
    push_c && stat_c.late_col |-> !stat_c.dribble && stat_c.error_summary;
  endproperty
  a_no_drib_col: assert property (p_no_drib_col) else $error("dribble with collision");

  property p_csum_word;
    @(posedge i_clk) disable iff (i_srst)
    i_ce && (s_reg.rx == RSW_RX_CSUM) && !s_reg.drop && !d_full_c
      |=> s_reg.dwp == $past(s_reg.dwp) + 1'b1;
  endproperty
  a_csum_word: assert property (p_csum_word) else $error("checksum word missing");

  property p_wdog_len;
    @(posedge i_clk) disable iff (i_srst)
    push_c && (s_reg.len > RSW_WDOG_BYTES) |-> stat_c.wdog && stat_c.too_long;
  endproperty
  a_wdog_len: assert property (p_wdog_len) else $error("watchdog bit missing");

endmodule

`default_nettype wire

//--- rsw_host_model.sv
// Host processor model: APB master that reads the receive fifos and runs the receiver
`timescale 1ns/1ps
`default_nettype none
module rsw_host_model
  import rsw_pkg::*;
(
  input wire logic i_clk,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output var rsw_apb_req_t o_apb
);
  // Bus idle from time zero
  initial o_apb = '0;

  // One transfer; waits for pready however long it takes, the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge i_clk);
    o_apb <= '{1'b1, 1'b0, w, a, wd};
    @(posedge i_clk);
    o_apb.penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
    end
    while (i_pready !== 1'b1);
    rd = i_prdata;
    err = i_pslverr;
    // Released address and data are inverted so stale values never look valid
    o_apb <= '{1'b0, 1'b0, w, ~a, ~wd};
  endtask

  // Stop reception by clearing the enable
  task automatic stop_rx;
    logic [31:0] d;
    logic e;
    xfer(1'b1, RSW_ADDR_CTRL, 32'h00000000, d, e);
  endtask

  // Resume reception by setting the enable again
  task automatic start_rx;
    logic [31:0] d;
    logic e;
    xfer(1'b1, RSW_ADDR_CTRL, 32'h00000001, d, e);
  endtask

  // The host itself clears the error flag; the block never recovers alone
  task automatic clear_error;
    logic [31:0] d;
    logic e;
    xfer(1'b1, RSW_ADDR_STAT, 32'h00000002, d, e);
  endtask

  // Soft reset after an underrun to regain sync with the fifos
  task automatic soft_reset;
    logic [31:0] d;
    logic e;
    xfer(1'b1, RSW_ADDR_SRST, 32'h00000001, d, e);
  endtask
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the receive status word and receiver control block
`timescale 1ns/1ps
`default_nettype none
module tb
  import rsw_pkg::*;
;
  // One frame case beside the low status half it should give
  typedef struct packed {
    logic [2:0] ctrl;
    logic [7:0] da0;
    logic [15:0] ltf;
    logic [13:0] n;
    logic [13:0] erpos;
    rsw_end_t e;
    logic [15:0] lo;
  } rsw_row_t;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  rsw_mil_t mac_interface_layer = '0;
  rsw_end_t ends = '0;
  rsw_apb_req_t apb;
  logic [31:0] prdata;
  logic pready, pslverr, rx_on, stop_p, err_f;
  logic [31:0] mismatches = 32'h0;
  logic [31:0] checks = 32'h0;
  logic [31:0] cyc = 32'h0;
  logic [31:0] stops = 32'h0;

  // Ordinary cases; erpos 3FFF means no receive error in the frame
  rsw_row_t rows [12] = '{
    '{3'h3, 8'h02, 16'h002E, 14'h0040, 14'h3FFF, 39'h0000000000, 16'h0000},
    '{3'h3, 8'hFF, 16'h0052, 14'h0064, 14'h3FFF, 39'h0000000000, 16'h2000},
    '{3'h7, 8'h01, 16'h0063, 14'h0046, 14'h3FFF, 39'h20A5A51234, 16'h9402},
    '{3'h3, 8'h02, 16'h0016, 14'h0028, 14'h0014, 39'h0000000000, 16'h880A},
    '{3'h3, 8'h02, 16'h003E, 14'h0050, 14'h3FFF, 39'h1400000000, 16'h8040},
    '{3'h3, 8'h02, 16'h002E, 14'h0040, 14'h3FFF, 39'h0400000000, 16'h0004},
    '{3'h3, 8'h02, 16'h002E, 14'h0040, 14'h3FFF, 39'h0B00000000, 16'h0004},
    '{3'h3, 8'h02, 16'h002E, 14'h0040, 14'h3FFF, 39'h4300000000, 16'h0000},
    '{3'h3, 8'h02, 16'h05DC, 14'h05EE, 14'h3FFF, 39'h0000000000, 16'h0000},
    '{3'h3, 8'h02, 16'h05DD, 14'h05EF, 14'h3FFF, 39'h0000000000, 16'h80A0},
    '{3'h3, 8'h02, 16'h07EE, 14'h0800, 14'h3FFF, 39'h0000000000, 16'h80A0},
    '{3'h7, 8'h02, 16'h07EF, 14'h0801, 14'h3FFF, 39'h0012345678, 16'h80B0}};

  // Large data fifo so the longest frame fits; small status fifo to reach overrun
  rsw_rx_ctrl #(.DDEPTH(1024), .SDEPTH(4)) dut (.i_clk(clk), .i_srst(srst), .i_ce(ce),
    .i_mil(mac_interface_layer), .i_end(ends), .i_apb(apb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_rx_on(rx_on), .o_receiver_stopped_pulse(stop_p),
    .o_receive_error_flag(err_f));

  rsw_host_model host (.i_clk(clk), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr), .o_apb(apb));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Verdict and end of run
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 32'h0 && checks > 32'h0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  // Byte i of a test frame: destination, counter bytes, length/type high byte first
  function automatic logic [7:0] fb(input int i, input rsw_row_t r);
    if (i < 6)
      return r.da0;
    if (i == 12)
      return r.ltf[15:8];
    if (i == 13)
      return r.ltf[7:0];
    return i[7:0];
  endfunction

  // Little endian packing, last partial word padded with zero
  function automatic logic [31:0] dword(input int k, input rsw_row_t r);
    logic [31:0] w;
    w = 32'h0;
    for (int j = 0; j < 4; j++)
      if (4 * k + j < int'(r.n))
        w[8 * j +: 8] = fb(4 * k + j, r);
    return w;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, d, q, e);
    cmp_bit(e, 1'b0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, a, 32'h0, q, e);
    cmp_word(q, exp);
  endtask

  // Status count field of the fifo info register
  task automatic scount_chk(input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, RSW_ADDR_INFO, 32'h0, q, e);
    cmp_word({29'h0, q[18:16]}, exp);
  endtask

  // One byte per cycle, then a gap wide enough for the checksum and status push
  task automatic frame(input rsw_row_t r);
    int i;
    repeat (2) @(posedge clk);
    for (i = 0; i < int'(r.n); i++)
    begin
      @(posedge clk);
      mac_interface_layer <= '{1'b1, i == 0, i == int'(r.n) - 1, i == int'(r.erpos), fb(i, r)};
      ends <= r.e;
    end
    @(posedge clk);
    mac_interface_layer <= '0;
    repeat (6) @(posedge clk);
  endtask

  task automatic check_row(input rsw_row_t r);
    int k;
    wr(RSW_ADDR_CTRL, {29'h0, r.ctrl});
    frame(r);
    rd_chk(RSW_ADDR_SPORT, {1'b0, r.e.filt_fail, r.n, r.lo});
    for (k = 0; k < (int'(r.n) + 3) / 4; k++)
      rd_chk(RSW_ADDR_DPORT, dword(k, r));
    if (r.ctrl[2])
      rd_chk(RSW_ADDR_DPORT, r.e.csum);
    rd_chk(RSW_ADDR_INFO, 32'h0);
  endtask

  // Cycle ceiling well above the expected run length
  always @(posedge clk)
  begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h0000EA60)
    begin
      mismatches++;
      stop_test;
    end
  end

  // Count stop pulses
  always @(posedge clk)
    if (stop_p === 1'b1)
      stops <= stops + 32'h1;

  initial
  begin
    logic [31:0] q;
    logic e;
    logic [31:0] s0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    cmp_word({28'h0, rx_on, stop_p, err_f, pready}, 32'h0);
    rd_chk(RSW_ADDR_CTRL, 32'h0);
    rd_chk(RSW_ADDR_STAT, 32'h0);
    host.xfer(1'b0, 8'h18, 32'h0, q, e);
    cmp_bit(e, 1'b1);
    foreach (rows[i])
      check_row(rows[i]);
    // Runt without pass-bad leaves nothing behind
    wr(RSW_ADDR_CTRL, 32'h1);
    frame(rows[3]);
    rd_chk(RSW_ADDR_INFO, 32'h0);
    // Stop gives one pulse, frames are ignored until restart
    s0 = stops;
    host.stop_rx;
    // Clock enable low freezes the pending stop
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    cmp_bit(rx_on, 1'b1);
    cmp_word(stops - s0, 32'h0);
    ce <= 1'b1;
    repeat (10) @(posedge clk);
    cmp_word(stops - s0, 32'h1);
    cmp_bit(rx_on, 1'b0);
    frame(rows[0]);
    rd_chk(RSW_ADDR_INFO, 32'h0);
    host.start_rx;
    frame(rows[0]);
    scount_chk(32'h1);
    // Fifth unread frame overruns the four-deep status fifo
    repeat (4) frame(rows[0]);
    cmp_bit(err_f, 1'b1);
    cmp_bit(rx_on, 1'b1);
    scount_chk(32'h4);
    host.soft_reset;
    rd_chk(RSW_ADDR_INFO, 32'h0);
    cmp_bit(err_f, 1'b0);
    rd_chk(RSW_ADDR_CTRL, 32'h1);
    // Underruns of both ports
    rd_chk(RSW_ADDR_SPORT, 32'h0);
    @(negedge clk);
    cmp_bit(err_f, 1'b1);
    host.clear_error;
    @(negedge clk);
    cmp_bit(err_f, 1'b0);
    rd_chk(RSW_ADDR_DPORT, 32'h0);
    @(negedge clk);
    cmp_bit(err_f, 1'b1);
    check_row(rows[1]);
    stop_test;
  end
endmodule
`default_nettype wire
